// ### design/core_reg_defs.svh
`ifndef CORE_REG_DEFS_SVH
`define CORE_REG_DEFS_SVH

// Clock period in picoseconds (200 MHz).
`define CLK_PERIOD_PS 5000
// Boot hold time in nanoseconds and its cycle count.
`define BOOT_HOLD_NS 90000
`define BOOT_HOLD_CYC ((`BOOT_HOLD_NS * 1000) / `CLK_PERIOD_PS)
// Delay from clock release to power-good, in nanoseconds, and its cycle count.
`define PGOOD_DELAY_NS 9000000
`define PGOOD_DELAY_CYC ((`PGOOD_DELAY_NS * 1000) / `CLK_PERIOD_PS)
// Power-good mask time in nanoseconds and its cycle count.
`define MASK_NS 130000
`define MASK_CYC ((`MASK_NS * 1000) / `CLK_PERIOD_PS)
// Extra mask time added for a large sleep step, in nanoseconds.
`define MASK_EXT_NS 130000
`define MASK_EXT_CYC ((`MASK_EXT_NS * 1000) / `CLK_PERIOD_PS)
// Code input settle time in nanoseconds; least time rounds up.
`define SETTLE_NS 400
`define SETTLE_CYC ((`SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Soft-start cycles spent on each code step.
`define SS_STEP_CYC 200
// Code width and reset value (code zero is the highest voltage, so start at all ones).
`define CODE_W 7
`define CODE_RESET 7'h7F

`endif

// ### design/core_reg_pkg.sv
package core_reg_pkg;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RAMP = 3'b001,
    ST_BOOT = 3'b010,
    ST_WAIT_PG = 3'b011,
    ST_RUN = 3'b100
  } seq_state_t;

  // Analog comparator decisions, already synchronous.
  typedef struct packed {
    logic below_low;
    logic above_high;
    logic code_below_300mv;
    logic large_drop;
    logic light_load;
    logic zero_cross;
  } sense_t;

  // Operating mode presented to the power stage.
  typedef struct packed {
    logic ripple_pulse_mode;
    logic continuous_conduction;
    logic discontinuous_conduction;
    logic dual_phase;
  } mode_t;

endpackage

// ### design/code_filter.sv
`include "core_reg_defs.svh"

// Accepts a new voltage code only after it has held still for the settle time.
module code_filter #(
  parameter int SETTLE = `SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic [`CODE_W-1:0] code_i,
  output logic [`CODE_W-1:0] code_o,
  output logic change_o
);

  logic [`CODE_W-1:0] last;
  logic [`CODE_W-1:0] next_last;
  logic [`CODE_W-1:0] next_code;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_change;

  // Restart the settle count on every input move; adopt once it expires.
  always_comb begin
    next_last = code_i;
    next_code = code_o;
    next_cnt = cnt;
    next_change = 1'b0;
    if (code_i != last) begin
      next_cnt = 8'h00;
    end else if (cnt < 8'(SETTLE)) begin
      next_cnt = cnt + 8'h01;
    end else if (enable_i && code_i != code_o) begin
      next_code = code_i;
      next_change = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      last <= `CODE_RESET;
      code_o <= `CODE_RESET;
      cnt <= 8'h00;
      change_o <= 1'b0;
    end else begin
      last <= next_last;
      code_o <= next_code;
      cnt <= next_cnt;
      change_o <= next_change;
    end
  end

endmodule

// ### design/gate_ctrl.sv
// Gate drive for one phase: complementary in continuous conduction, low side held off after the zero crossing in discontinuous.
module gate_ctrl (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic pwm_i,
  input wire logic dcm_i,
  input wire logic zero_cross_i,
  output logic high_side_o,
  output logic low_side_o
);

  logic idle;
  logic next_idle;
  logic next_high;
  logic next_low;

  // Low side turns off at the zero crossing in discontinuous mode and stays off until the next pulse.
  always_comb begin
    next_idle = idle;
    if (pwm_i || !dcm_i || !run_i) begin
      next_idle = 1'b0;
    end else if (zero_cross_i) begin
      next_idle = 1'b1;
    end
    next_high = run_i && pwm_i;
    next_low = run_i && !pwm_i && !next_idle;
  end

  // Output registers.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      idle <= 1'b0;
      high_side_o <= 1'b0;
      low_side_o <= 1'b0;
    end else begin
      idle <= next_idle;
      high_side_o <= next_high;
      low_side_o <= next_low;
    end
  end

endmodule

// ### design/core_regulator_sequencer.sv
`include "core_reg_defs.svh"

module core_regulator_sequencer #(
  parameter int BOOT_HOLD = `BOOT_HOLD_CYC,
  parameter int PGOOD_DELAY = `PGOOD_DELAY_CYC,
  parameter int MASK = `MASK_CYC,
  parameter int MASK_EXT = `MASK_EXT_CYC,
  parameter int SS_STEP = `SS_STEP_CYC,
  parameter logic [`CODE_W-1:0] BOOT_CODE = 7'h30
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic [`CODE_W-1:0] voltage_code_i,
  input wire logic deeper_sleep_request_i,
  input wire logic single_phase_cfg_i,
  input wire logic pwm_pulse_i,
  input wire core_reg_pkg::sense_t sense_i,
  output logic cpu_clock_release_n_o,
  output logic output_in_window_o,
  output logic [`CODE_W-1:0] target_code_o,
  output logic on_the_fly_code_change_o,
  output core_reg_pkg::mode_t mode_o,
  output logic pwm_o,
  output logic high_side_o,
  output logic low_side_o
);

  core_reg_pkg::seq_state_t state;
  core_reg_pkg::seq_state_t next_state;
  logic [21:0] timer;
  logic [21:0] next_timer;
  logic [`CODE_W-1:0] target;
  logic [`CODE_W-1:0] next_target;
  logic [`CODE_W-1:0] filt_code;
  logic filt_change;
  logic [16:0] mask_cnt;
  logic [16:0] next_mask_cnt;
  logic sleep_d;
  logic next_sleep_d;
  logic pg_armed;
  logic next_pg_armed;
  logic next_window;
  logic next_clk_rel_n;
  logic next_otf;
  logic in_window;
  logic masked;
  logic sleep_edge;
  logic running;
  core_reg_pkg::mode_t next_mode;
  logic next_pwm;
  logic released;
  logic active;
  logic [7:0] ss_div;
  logic [7:0] next_ss_div;
  logic ss_tick;

  // True once the clock release has gone out; code inputs count only from then on.
  function automatic logic is_released(input core_reg_pkg::seq_state_t s);
    return (s == core_reg_pkg::ST_WAIT_PG) || (s == core_reg_pkg::ST_RUN);
  endfunction

  // True while the regulator is switching: enabled and out of the off state.
  function automatic logic is_active(input logic en, input core_reg_pkg::seq_state_t s);
    return en && (s != core_reg_pkg::ST_OFF);
  endfunction

  // True on the last cycle of an interval that is counted from zero.
  function automatic logic timer_done(input logic [21:0] t, input int limit);
    return t >= 22'(limit - 1);
  endfunction

  // Shared state decodes.
  assign released = is_released(state);
  assign active = is_active(enable_i, state);

  // Voltage code inputs are settled before use; only accepted once clock is released.
  code_filter #(
    .SETTLE(`SETTLE_CYC)
  ) u_filter (
    .clk_i(clk_i),
    .nrst_i(nrst_i && enable_i),
    .enable_i(released),
    .code_i(voltage_code_i),
    .code_o(filt_code),
    .change_o(filt_change)
  );

  // Soft-start step divider: one enable pulse every SS_STEP cycles while ramping.
  always_comb begin
    next_ss_div = ss_div + 8'h01;
    ss_tick = 1'b0;
    if (state != core_reg_pkg::ST_RAMP) begin
      next_ss_div = 8'h00;
    end else if (ss_div >= 8'(SS_STEP - 1)) begin
      next_ss_div = 8'h00;
      ss_tick = 1'b1;
    end
  end

  // Divider register.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ss_div <= 8'h00;
    end else begin
      ss_div <= next_ss_div;
    end
  end

  // Start-up sequencer: ramp, boot hold, clock release, power-good delay.
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_target = target;
    next_clk_rel_n = cpu_clock_release_n_o;
    next_pg_armed = pg_armed;
    case (state)
      core_reg_pkg::ST_OFF: begin
        next_target = `CODE_RESET;
        next_timer = 22'h000000;
        if (enable_i) begin
          next_state = core_reg_pkg::ST_RAMP;
        end
      end
      core_reg_pkg::ST_RAMP: begin
        if (target == BOOT_CODE) begin
          next_state = core_reg_pkg::ST_BOOT;
          next_timer = 22'h000000;
        end else if (ss_tick) begin
          next_target = (target > BOOT_CODE) ? target - 7'h01 : target + 7'h01;
        end
      end
      core_reg_pkg::ST_BOOT: begin
        if (timer_done(timer, BOOT_HOLD)) begin
          next_state = core_reg_pkg::ST_WAIT_PG;
          next_clk_rel_n = 1'b0;
          next_timer = 22'h000000;
        end else begin
          next_timer = timer + 22'h000001;
        end
      end
      core_reg_pkg::ST_WAIT_PG: begin
        if (filt_change) begin
          next_target = filt_code;
        end
        if (timer_done(timer, PGOOD_DELAY)) begin
          next_state = core_reg_pkg::ST_RUN;
          next_pg_armed = 1'b1;
        end else begin
          next_timer = timer + 22'h000001;
        end
      end
      core_reg_pkg::ST_RUN: begin
        if (filt_change) begin
          next_target = filt_code;
        end
      end
      default: begin
        next_state = core_reg_pkg::ST_OFF;
      end
    endcase
    if (!enable_i) begin
      next_state = core_reg_pkg::ST_OFF;
      next_clk_rel_n = 1'b1;
      next_pg_armed = 1'b0;
      next_target = `CODE_RESET;
      next_timer = 22'h000000;
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= core_reg_pkg::ST_OFF;
      timer <= 22'h000000;
      target <= `CODE_RESET;
      cpu_clock_release_n_o <= 1'b1;
      pg_armed <= 1'b0;
      target_code_o <= `CODE_RESET;
    end else begin
      state <= next_state;
      timer <= next_timer;
      target <= next_target;
      cpu_clock_release_n_o <= next_clk_rel_n;
      pg_armed <= next_pg_armed;
      target_code_o <= next_target;
    end
  end

  // Power-good masking timer; a large sleep drop keeps its longer mask even if a code change lands with it.
  always_comb begin
    running = released;
    sleep_edge = running && (deeper_sleep_request_i != sleep_d);
    next_sleep_d = deeper_sleep_request_i;
    next_mask_cnt = mask_cnt;
    if (!enable_i) begin
      next_mask_cnt = 17'h00000;
    end else if (sleep_edge && sense_i.large_drop) begin
      next_mask_cnt = 17'(MASK + MASK_EXT);
    end else if (filt_change) begin
      next_mask_cnt = 17'(MASK);
    end else if (sleep_edge) begin
      next_mask_cnt = 17'(MASK);
    end else if (mask_cnt != 17'h00000) begin
      next_mask_cnt = mask_cnt - 17'h00001;
    end
    masked = (mask_cnt != 17'h00000);
    next_otf = masked || filt_change || sleep_edge;
  end

  // Mask registers; the sleep level is kept to find its edges.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mask_cnt <= 17'h00000;
      sleep_d <= 1'b0;
      on_the_fly_code_change_o <= 1'b0;
    end else begin
      mask_cnt <= next_mask_cnt;
      sleep_d <= next_sleep_d;
      on_the_fly_code_change_o <= next_otf && enable_i;
    end
  end

  // Power-good window; the last value is frozen while the mask runs.
  always_comb begin
    in_window = !sense_i.above_high && (sense_i.code_below_300mv || !sense_i.below_low);
    next_window = output_in_window_o;
    if (!pg_armed || !enable_i) begin
      next_window = 1'b0;
    end else if (!masked) begin
      next_window = in_window;
    end
  end

  // First rise after the start-up delay is gated by the window check as well.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      output_in_window_o <= 1'b0;
    end else begin
      output_in_window_o <= next_window;
    end
  end

  // Mode selection for the power stage.
  always_comb begin
    next_mode = '0;
    next_pwm = 1'b0;
    if (active) begin
      next_pwm = pwm_pulse_i;
      if (next_otf) begin
        next_mode.continuous_conduction = 1'b1;
        next_mode.dual_phase = single_phase_cfg_i;
      end else if (deeper_sleep_request_i) begin
        next_mode.ripple_pulse_mode = 1'b1;
        next_mode.discontinuous_conduction = sense_i.light_load;
        next_mode.continuous_conduction = !sense_i.light_load;
      end else begin
        next_mode.continuous_conduction = 1'b1;
        next_mode.ripple_pulse_mode = single_phase_cfg_i;
      end
    end
  end

  // Mode and pulse registers; all low in shutdown.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mode_o <= '0;
      pwm_o <= 1'b0;
    end else begin
      mode_o <= next_mode;
      pwm_o <= next_pwm;
    end
  end

  // Gate drive for the integrated phase.
  gate_ctrl u_gate (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(active),
    .pwm_i(pwm_pulse_i),
    .dcm_i(next_mode.discontinuous_conduction),
    .zero_cross_i(sense_i.zero_cross),
    .high_side_o(high_side_o),
    .low_side_o(low_side_o)
  );

endmodule

// ### testbench/core_regulator_sequencer_checker.sv
`include "core_reg_defs.svh"

// Watches the sequencer ports for timing and mode relations.
module core_regulator_sequencer_checker #(
  parameter logic [`CODE_W-1:0] BOOT_CODE = 7'h30
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire core_reg_pkg::sense_t sense_i,
  input wire logic cpu_clock_release_n_o,
  input wire logic output_in_window_o,
  input wire logic [`CODE_W-1:0] target_code_o,
  input wire logic on_the_fly_code_change_o,
  input wire core_reg_pkg::mode_t mode_o,
  input wire logic pwm_o,
  input wire logic high_side_o,
  input wire logic low_side_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_shut;
    !enable_i |=> cpu_clock_release_n_o && !output_in_window_o && !pwm_o && !high_side_o && !low_side_o;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown outputs active");
  property p_step;
    enable_i && $past(enable_i) && cpu_clock_release_n_o && target_code_o != $past(target_code_o)
      |-> target_code_o == $past(target_code_o) - 7'h01;
  endproperty
  a_step: assert property (p_step) else $error("soft start skipped a code");
  property p_boot;
    cpu_clock_release_n_o |-> target_code_o >= BOOT_CODE;
  endproperty
  a_boot: assert property (p_boot) else $error("target passed boot code");
  property p_comp;
    !(high_side_o && low_side_o);
  endproperty
  a_comp: assert property (p_comp) else $error("both gates on");
  property p_win;
    output_in_window_o |-> !$past(sense_i.above_high) && (!$past(sense_i.below_low) || $past(sense_i.code_below_300mv));
  endproperty
  a_win: assert property (p_win) else $error("power good outside window");
  property p_dly;
    $fell(cpu_clock_release_n_o) |-> !output_in_window_o [*8];
  endproperty
  a_dly: assert property (p_dly) else $error("power good too early");
  property p_otf;
    on_the_fly_code_change_o && $past(on_the_fly_code_change_o)
      |-> mode_o.continuous_conduction && !mode_o.ripple_pulse_mode;
  endproperty
  a_otf: assert property (p_otf) else $error("transient not forced to fixed frequency");
  property p_mask;
    $rose(on_the_fly_code_change_o) |-> on_the_fly_code_change_o [*8];
  endproperty
  a_mask: assert property (p_mask) else $error("mask too short");
  property p_zc;
    mode_o.discontinuous_conduction && sense_i.zero_cross |-> ##[1:2] !low_side_o;
  endproperty
  a_zc: assert property (p_zc) else $error("low side on after zero cross");
endmodule

bind core_regulator_sequencer core_regulator_sequencer_checker #(.BOOT_CODE(BOOT_CODE)) chk_i (
  .clk_i(clk_i), .nrst_i(nrst_i), .enable_i(enable_i), .sense_i(sense_i),
  .cpu_clock_release_n_o(cpu_clock_release_n_o), .output_in_window_o(output_in_window_o),
  .target_code_o(target_code_o), .on_the_fly_code_change_o(on_the_fly_code_change_o),
  .mode_o(mode_o), .pwm_o(pwm_o), .high_side_o(high_side_o), .low_side_o(low_side_o));

// ### testbench/host_cpu_model.sv
`include "core_reg_defs.svh"

// Processor side: moves the code one step per request and drives sleep.
module host_cpu_model #(
  parameter logic [`CODE_W-1:0] START = 7'h78
) (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic up_i,
  input wire logic sleep_i,
  output logic [`CODE_W-1:0] code_o,
  output logic sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`CODE_W-1:0] code = START;
  logic sleep_lvl = 1'b0;

  // Each request moves the code by exactly one step, just after the edge.
  always @(posedge clk_i) begin
    if (step_i) code <= #1 up_i ? code + 7'h01 : code - 7'h01;
    sleep_lvl <= #1 sleep_i;
  end

  // Pins toward the regulator, each with a single driver.
  assign code_o = code;
  assign sleep_o = sleep_lvl;
endmodule

// ### testbench/core_regulator_sequencer_test.sv
`include "core_reg_defs.svh"

// Sequencer bench with shortened counts.
module core_regulator_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] BOOT = 7'h78;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic enable_i = 1'b0;
  logic single_phase_cfg_i = 1'b1;
  logic pwm_pulse_i = 1'b0;
  core_reg_pkg::sense_t sense_i = '0;
  logic step = 1'b0;
  logic up = 1'b0;
  logic sleep = 1'b0;
  logic idle;
  logic [6:0] code;
  logic slp, rel_n, pg, otf, pwm, hs, ls;
  logic [6:0] tgt;
  core_reg_pkg::mode_t mode;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  core_regulator_sequencer #(.BOOT_HOLD(20), .PGOOD_DELAY(50), .MASK(120), .MASK_EXT(10), .SS_STEP(2),
    .BOOT_CODE(BOOT)) core_regulator_sequencer_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .enable_i(enable_i), .voltage_code_i(code),
    .deeper_sleep_request_i(slp), .single_phase_cfg_i(single_phase_cfg_i), .pwm_pulse_i(pwm_pulse_i),
    .sense_i(sense_i), .cpu_clock_release_n_o(rel_n), .output_in_window_o(pg), .target_code_o(tgt),
    .on_the_fly_code_change_o(otf), .mode_o(mode), .pwm_o(pwm), .high_side_o(hs), .low_side_o(ls));
  host_cpu_model #(.START(BOOT)) host_cpu_model_i (
    .clk_i(clk_i), .step_i(step), .up_i(up), .sleep_i(sleep), .code_o(code), .sleep_o(slp));

  // Clock, modulator pulse and hang guard.
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) #1 pwm_pulse_i = ~pwm_pulse_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic hop(input logic dir);
    up = dir;
    step = 1'b1;
    cyc(1);
    step = 1'b0;
    cyc(1);
  endtask

  // Soft start with code noise during the ramp, boot hold and delayed power good.
  task automatic t_startup();
    enable_i = 1'b1;
    cyc(5);
    chk(tgt < 7'h7F, 1, "ramp");
    hop(1);
    hop(0);
    for (n = 9; n < 300 && rel_n !== 1'b0; n++) cyc(1);
    chk(tgt, BOOT, "boot code");
    chk(n >= 34, 1, "boot hold");
    cyc(40);
    chk(pg, 0, "pg early");
    for (n = 0; n < 60 && pg !== 1'b1; n++) cyc(1);
    chk(pg, 1, "pg");
  endtask

  // Code step: settle filter, forced mode and mask restart.
  task automatic t_code();
    hop(0);
    cyc(40);
    chk(tgt, BOOT, "settle");
    for (n = 0; n < 100 && tgt !== BOOT - 7'h01; n++) cyc(1);
    chk(tgt, BOOT - 7'h01, "adopt");
    chk(otf, 1, "transient");
    chk({mode.continuous_conduction, mode.ripple_pulse_mode, mode.dual_phase}, 3'b101, "mode");
    hop(1);
    for (n = 0; n < 100 && tgt !== BOOT; n++) cyc(1);
    cyc(100);
    chk(otf, 1, "restart");
    for (n = 0; n < 60 && otf !== 1'b0; n++) cyc(1);
    chk(otf, 0, "mask end");
    chk(pg, 1, "pg held");
  endtask

  // Window limits, with the lower limit dropped for low codes.
  task automatic t_window();
    chk({mode.continuous_conduction, mode.ripple_pulse_mode}, 2'b11, "single phase normal");
    sense_i.above_high = 1'b1;
    cyc(3);
    chk(pg, 0, "above");
    sense_i.above_high = 1'b0;
    sense_i.below_low = 1'b1;
    sense_i.code_below_300mv = 1'b1;
    cyc(3);
    chk(pg, 1, "low code");
    sense_i.code_below_300mv = 1'b0;
    cyc(3);
    chk(pg, 0, "below");
    sense_i.below_low = 1'b0;
    cyc(3);
  endtask

  // Sleep: extended mask, ripple mode and discontinuous conduction at light load.
  task automatic t_sleep();
    sense_i.light_load = 1'b1;
    sense_i.large_drop = 1'b1;
    sleep = 1'b1;
    cyc(126);
    chk(otf, 1, "mask ext");
    for (n = 0; n < 60 && otf !== 1'b0; n++) cyc(1);
    cyc(3);
    chk({mode.ripple_pulse_mode, mode.discontinuous_conduction}, 2'b11, "dcm");
    sense_i.zero_cross = 1'b1;
    idle = 1'b0;
    for (n = 0; n < 10; n++) begin
      cyc(1);
      idle = idle | (!hs && !ls);
    end
    chk(idle, 1, "idle");
    chk(ls, 0, "zero cross");
    sense_i.zero_cross = 1'b0;
    sense_i.light_load = 1'b0;
    cyc(5);
    chk({mode.continuous_conduction, mode.discontinuous_conduction}, 2'b10, "load up");
    single_phase_cfg_i = 1'b0;
    sleep = 1'b0;
    sense_i.large_drop = 1'b0;
    cyc(3);
    chk({mode.continuous_conduction, mode.ripple_pulse_mode, mode.dual_phase}, 3'b100, "exit transient");
    for (n = 0; n < 200 && otf !== 1'b0; n++) cyc(1);
    chk({mode.continuous_conduction, mode.ripple_pulse_mode}, 2'b10, "awake");
  endtask

  // Shutdown on enable low.
  task automatic t_shutdown();
    enable_i = 1'b0;
    cyc(3);
    chk({rel_n, pg, hs, ls, pwm}, 5'b10000, "off");
    chk(tgt, 7'h7F, "off code");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    cyc(12);
    nrst_i = 1'b1;
    cyc(2);
    t_startup();
    $display("startup done");
    t_code();
    $display("code change done");
    t_window();
    $display("window done");
    t_sleep();
    $display("sleep done");
    t_shutdown();
    $display("shutdown done");
    end_of_test();
  end
endmodule
